// >>> inc/hdr_defs.vh
// Purpose: constants for the hub descriptor responder
// Assumes: plain Verilog-2005 include
// Notes: offsets are register addresses on the configuration port
`ifndef HDR_DEFS_VH
`define HDR_DEFS_VH
// configuration register addresses
`define HDR_CFG1_ADDR 8'h06
`define HDR_CCBP_ADDR 8'h0F
`define HDR_CCSP_ADDR 8'h10
`define HDR_NRPM_ADDR 8'h11
`define HDR_LANGH_ADDR 8'h12
`define HDR_LANGL_ADDR 8'h13
`define HDR_MLEN_ADDR 8'h14
`define HDR_PLEN_ADDR 8'h15
`define HDR_SLEN_ADDR 8'h16
`define HDR_MTXT_BASE 8'h20
`define HDR_PTXT_BASE 8'h40
`define HDR_STXT_BASE 8'h60
`define HDR_TXT_SPAN 8'h20
// field positions
`define HDR_CFG1_SELFPWR_BIT 7
// reset values
`define HDR_CFG1_RST 8'h00
`define HDR_CCBP_RST 8'h32
`define HDR_CCSP_RST 8'h01
`define HDR_NRPM_RST 8'h00
`define HDR_LANGH_RST 8'h04
`define HDR_LANGL_RST 8'h09
`define HDR_LEN_RST 8'h00
// descriptor constants
`define HDR_TYPE_HUB 8'h29
`define HDR_TYPE_HUB_OLD 8'h00
`define HDR_TYPE_STRING 8'h03
`define HDR_HUB_LEN 8'h09
`define HDR_STR0_LEN 8'h04
`define HDR_PPCM 8'hFF
`define HDR_STR_MAX 8'h3C
`define HDR_STR_OVH 8'h02
// descriptor selectors
`define HDR_SEL_HUB 3'h0
`define HDR_SEL_STR0 3'h1
`define HDR_SEL_MFR 3'h2
`define HDR_SEL_PRD 3'h3
`define HDR_SEL_SER 3'h4
`endif

// >>> rtl/hdr_text_store.v
// Purpose: byte store for the three descriptor strings
// Assumes: one write port, one asynchronous read port
// Notes: each string takes a 32-byte window; 30 characters need 60 bytes,
//        so a full 60-byte string runs past its window into the next one, or past 8'h7F for the serial string
`include "hdr_defs.vh"
module hdr_text_store (
    // clock
    input wire clk,
    // write port
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    // read port
    input wire [7:0] rd_addr,
    output wire [7:0] rd_data
);
    reg [7:0] mem_r [0:255];
    always @(posedge clk) begin
        if (wr_en)
            mem_r[wr_addr] <= wr_data;
    end
    assign rd_data = mem_r[rd_addr];
endmodule // hdr_text_store

// >>> rtl/hdr_responder.v
// Purpose: serves hub class tail and string descriptor bytes
// Assumes: config port writes come from defaults or serial load
// Notes: string bytes held in text store at base + index (60 bytes max)
`include "hdr_defs.vh"
module hdr_responder (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // configuration port
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    // descriptor request
    input wire req_valid,
    input wire [7:0] req_type,
    input wire [2:0] req_sel,
    input wire [15:0] req_len,
    input wire [7:0] hub_head_len,
    input wire [7:0] hub_head_ports,
    input wire [15:0] hub_head_char,
    input wire [7:0] hub_head_pwrtime,
    output reg req_reject,
    // byte stream
    input wire out_ready,
    output reg out_valid,
    output reg [7:0] out_data,
    output reg out_last,
    output reg busy
);
    reg [7:0] cfg1_r, ccbp_r, ccsp_r, nrpm_r, langh_r, langl_r;
    reg [7:0] mlen_r, plen_r, slen_r;
    reg [2:0] sel_r;
    reg [7:0] idx_r;
    reg [15:0] rem_r;
    reg [7:0] dlen;
    reg [7:0] slen;
    reg [7:0] base;
    reg [7:0] byte_nxt;
    reg [7:0] cfg_nxt;
    wire [7:0] txt_data;
    wire [7:0] txt_rd_addr;
    wire txt_wr;
    wire hub_req;
    wire str_req;

    // string bytes live in the store, not in flops, to keep area small
    assign txt_wr = cfg_wr && (cfg_addr >= `HDR_MTXT_BASE);
    assign txt_rd_addr = base + idx_r - `HDR_STR_OVH;

    hdr_text_store u_txt (
        .clk(clk),
        .wr_en(txt_wr),
        .wr_addr(cfg_addr),
        .wr_data(cfg_wdata),
        .rd_addr(txt_rd_addr),
        .rd_data(txt_data)
    );

    always @(posedge clk) begin
        if (sys_rst) begin
            cfg1_r <= `HDR_CFG1_RST;
            ccbp_r <= `HDR_CCBP_RST;
            ccsp_r <= `HDR_CCSP_RST;
            nrpm_r <= `HDR_NRPM_RST;
            langh_r <= `HDR_LANGH_RST;
            langl_r <= `HDR_LANGL_RST;
            mlen_r <= `HDR_LEN_RST;
            plen_r <= `HDR_LEN_RST;
            slen_r <= `HDR_LEN_RST;
        end else if (cfg_wr) begin
            case (cfg_addr)
                `HDR_CFG1_ADDR: cfg1_r <= cfg_wdata;
                `HDR_CCBP_ADDR: ccbp_r <= cfg_wdata;
                `HDR_CCSP_ADDR: ccsp_r <= cfg_wdata;
                `HDR_NRPM_ADDR: nrpm_r <= cfg_wdata;
                `HDR_LANGH_ADDR: langh_r <= cfg_wdata;
                `HDR_LANGL_ADDR: langl_r <= cfg_wdata;
                // lengths above 60 bytes are clipped to 60; reads past 32 bytes leave the window
                `HDR_MLEN_ADDR: mlen_r <= (cfg_wdata > `HDR_STR_MAX) ?
                    `HDR_STR_MAX : cfg_wdata;
                `HDR_PLEN_ADDR: plen_r <= (cfg_wdata > `HDR_STR_MAX) ?
                    `HDR_STR_MAX : cfg_wdata;
                `HDR_SLEN_ADDR: slen_r <= (cfg_wdata > `HDR_STR_MAX) ?
                    `HDR_STR_MAX : cfg_wdata;
                default: ;
            endcase
        end
    end

    // readback of configuration
    always @* begin
        case (cfg_addr)
            `HDR_CFG1_ADDR: cfg_nxt = cfg1_r;
            `HDR_CCBP_ADDR: cfg_nxt = ccbp_r;
            `HDR_CCSP_ADDR: cfg_nxt = ccsp_r;
            `HDR_NRPM_ADDR: cfg_nxt = nrpm_r;
            `HDR_LANGH_ADDR: cfg_nxt = langh_r;
            `HDR_LANGL_ADDR: cfg_nxt = langl_r;
            `HDR_MLEN_ADDR: cfg_nxt = mlen_r;
            `HDR_PLEN_ADDR: cfg_nxt = plen_r;
            `HDR_SLEN_ADDR: cfg_nxt = slen_r;
            default: cfg_nxt = 8'h00;
        endcase
    end

    assign hub_req = (req_sel == `HDR_SEL_HUB) &&
        ((req_type == `HDR_TYPE_HUB) ||
         (req_type == `HDR_TYPE_HUB_OLD));
    assign str_req = (req_type == `HDR_TYPE_STRING) &&
        (req_sel >= `HDR_SEL_STR0) && (req_sel <= `HDR_SEL_SER);

    // descriptor length and string base of the active selection
    always @* begin
        slen = 8'h00;
        base = 8'h00;
        case (sel_r)
            `HDR_SEL_HUB: dlen = `HDR_HUB_LEN;
            `HDR_SEL_STR0: dlen = `HDR_STR0_LEN;
            `HDR_SEL_MFR: begin
                slen = mlen_r;
                base = `HDR_MTXT_BASE;
            end
            `HDR_SEL_PRD: begin
                slen = plen_r;
                base = `HDR_PTXT_BASE;
            end
            `HDR_SEL_SER: begin
                slen = slen_r;
                base = `HDR_STXT_BASE;
            end
            default: dlen = 8'h00;
        endcase
        if (sel_r >= `HDR_SEL_MFR)
            dlen = slen + `HDR_STR_OVH;
        else if (sel_r == `HDR_SEL_HUB)
            dlen = `HDR_HUB_LEN;
        else
            dlen = `HDR_STR0_LEN;
    end

    // byte at the current offset
    always @* begin
        byte_nxt = 8'h00;
        if (sel_r == `HDR_SEL_HUB) begin
            case (idx_r)
                8'h00: byte_nxt = hub_head_len;
                8'h01: byte_nxt = `HDR_TYPE_HUB;
                8'h02: byte_nxt = hub_head_ports;
                8'h03: byte_nxt = hub_head_char[7:0];
                8'h04: byte_nxt = hub_head_char[15:8];
                8'h05: byte_nxt = hub_head_pwrtime;
                8'h06: byte_nxt = cfg1_r[`HDR_CFG1_SELFPWR_BIT] ?
                    ccsp_r : ccbp_r;
                8'h07: byte_nxt = nrpm_r;
                8'h08: byte_nxt = `HDR_PPCM;
                default: byte_nxt = 8'h00;
            endcase
        end else if (idx_r == 8'h00) begin
            byte_nxt = dlen;
        end else if (idx_r == 8'h01) begin
            byte_nxt = `HDR_TYPE_STRING;
        end else if (sel_r == `HDR_SEL_STR0) begin
            byte_nxt = (idx_r == 8'h02) ? langl_r : langh_r;
        end else begin
            byte_nxt = txt_data;
        end
    end

    // streaming: one byte offered per cycle, advanced on out_ready
    always @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_last <= 1'b0;
            req_reject <= 1'b0;
            cfg_rdata <= 8'h00;
            sel_r <= 3'h0;
            idx_r <= 8'h00;
            rem_r <= 16'h0000;
        end else begin
            req_reject <= 1'b0;
            if (cfg_rd)
                cfg_rdata <= cfg_nxt;
            if (!busy) begin
                out_valid <= 1'b0;
                out_last <= 1'b0;
                if (req_valid) begin
                    if ((hub_req || str_req) && req_len != 16'h0000) begin
                        busy <= 1'b1;
                        sel_r <= req_sel;
                        idx_r <= 8'h00;
                        rem_r <= req_len;
                    end else begin
                        req_reject <= 1'b1;
                    end
                end
            end else if (!out_valid || out_ready) begin
                if (out_valid && out_last) begin
                    busy <= 1'b0;
                    out_valid <= 1'b0;
                    out_last <= 1'b0;
                end else begin
                    out_valid <= 1'b1;
                    out_data <= byte_nxt;
                    // final byte: descriptor end or host limit, whichever first
                    out_last <= (idx_r == dlen - 8'h01) ||
                        (rem_r == 16'h0001);
                    idx_r <= idx_r + 8'h01;
                    rem_r <= rem_r - 16'h0001;
                end
            end
        end
    end
endmodule // hdr_responder

// >>> testbench/hdr_chk_sva.sv
// Purpose: port checker for hdr_responder
// Assumes: descriptor constants and selector codes of hdr_defs.vh
// Notes: idx_r counts handshakes since the last request seen while idle, taken or refused
`include "hdr_defs.vh"
module hdr_chk (
    input wire clk, sys_rst, req_valid, req_reject, busy,
    input wire out_ready, out_valid, out_last,
    input wire [2:0] req_sel,
    input wire [15:0] req_len,
    input wire [7:0] out_data
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] sel_r;
    reg [15:0] len_r, idx_r;
    wire hub = sel_r == `HDR_SEL_HUB;
    always @(posedge clk) begin
        if (req_valid && !busy) begin
            sel_r <= req_sel;
            len_r <= req_len;
            idx_r <= 16'h0000;
        end else if (out_valid && out_ready) begin
            idx_r <= idx_r + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    reject_one_a: assert property (req_reject |=> !req_reject)
        else $error("reject longer than one cycle");
    reject_quiet_a: assert property (req_reject |-> !out_valid && !busy)
        else $error("refused request still transfers");
    take_busy_a: assert property (req_valid && !busy |=> busy ^ req_reject)
        else $error("request neither taken nor refused");
    first_byte_a: assert property ($rose(busy) |=> out_valid)
        else $error("first byte late");
    hold_byte_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data)) else $error("byte dropped");
    hub_tail_a: assert property (hub && out_valid && idx_r == 16'h0008
        |-> out_data == `HDR_PPCM) else $error("byte 8 wrong");
    desc_type_a: assert property (out_valid && idx_r == 16'h0001 |->
        out_data == (hub ? `HDR_TYPE_HUB : `HDR_TYPE_STRING))
        else $error("type byte wrong");
    str0_len_a: assert property (sel_r == `HDR_SEL_STR0 && out_valid
        && idx_r == 16'h0000 |-> out_data == `HDR_STR0_LEN)
        else $error("string zero length wrong");
    hub_stop_a: assert property (hub && out_valid && out_last |->
        idx_r == (len_r < 16'h0009 ? len_r - 16'h0001 : 16'h0008))
        else $error("hub stream stops at wrong byte");
    end_quiet_a: assert property (out_valid && out_ready && out_last
        |=> !out_valid && !busy) else $error("stream runs past last");
    cover property (req_reject);
    cover property (hub && out_valid && out_last);
    cover property (out_valid && !out_ready);
endmodule // hdr_chk
bind hdr_responder hdr_chk u_chk (.*);

// >>> testbench/hdr_host_model.sv
// Purpose: host side sink for the descriptor byte stream
// Assumes: a byte moves when out_valid and out_ready meet at an edge
// Notes: slow mode stalls every other cycle so holding gets exercised
module hdr_host_model (
    input wire clk, slow, out_valid, out_last,
    input wire [7:0] out_data,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    initial out_ready = 1'b1;
    always @(posedge clk) begin
        if (out_valid && out_ready) q.push_back(out_data);
        out_ready <= slow ? !out_ready : 1'b1;
    end
endmodule // hdr_host_model

// >>> testbench/tb.sv
// Purpose: self-checking bench for hdr_responder
// Assumes: host model gathers each stream into its queue
// Notes: string text is written as base address xor index
`include "hdr_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, req_valid = 0;
    logic slow = 0, req_reject, out_valid, out_last, busy, out_ready;
    logic [7:0] cfg_addr = 0, cfg_wdata = 0, req_type = 0;
    logic [7:0] cfg_rdata, out_data;
    logic [2:0] req_sel = 0;
    logic [15:0] req_len = 0;
    int err_total = 0, checks_done = 0, cyc = 0, rej_n = 0;
    logic [7:0] exp_q[$];
    hdr_responder DUT (.clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .req_valid, .req_type, .req_sel, .req_len,
        .hub_head_len(8'h09), .hub_head_ports(8'h03),
        .hub_head_char(16'h0000), .hub_head_pwrtime(8'h32), .req_reject,
        .out_ready, .out_valid, .out_data, .out_last, .busy);
    hdr_host_model host (.clk, .slow, .out_valid, .out_last, .out_data,
        .out_ready);
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        rej_n <= rej_n + int'(req_reject === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test;
        end
    end
    task finish_test;
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, cfg_rdata}, {8'h00, e});
    endtask
    // waits on busy with a bound so a stuck transfer cannot hang the run
    task get(input logic [7:0] t, input logic [2:0] s, input logic [15:0] n);
        int k;
        k = 0;
        host.q.delete();
        @(posedge clk);
        req_valid <= 1'b1;
        req_type <= t;
        req_sel <= s;
        req_len <= n;
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        while (busy === 1'b1 && k < 500) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0000, busy}, 16'h0000);
        @(posedge clk);
    endtask
    task cmp;
        chk(16'(host.q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk({8'h00, host.q[i]}, {8'h00, exp_q[i]});
    endtask
    task t_str(input logic [2:0] s, input logic [7:0] la, b, n);
        exp_q = '{n + 8'h02, 8'h03};
        for (int i = 0; i < n; i++) begin
            wr(b + 8'(i), b ^ 8'(i));
            exp_q.push_back(b ^ 8'(i));
        end
        wr(la, n);
        get(8'h03, s, 16'h00FF);
        cmp;
    endtask
    task t_reject;
        int n0;
        n0 = rej_n;
        get(8'h03, 3'h0, 16'h0009);
        get(8'h29, 3'h2, 16'h0009);
        get(8'h29, 3'h0, 16'h0000);
        repeat (2) @(negedge clk);
        chk(16'(rej_n - n0), 16'h0003);
        chk(16'(host.q.size()), 16'h0000);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'h0F, 8'h32);
        rd(8'h10, 8'h01);
        rd(8'h11, 8'h00);
        wr(8'h11, 8'hA5);
        wr(8'h0F, 8'h64);
        get(8'h29, 3'h0, 16'h0009);
        exp_q = '{8'h09, 8'h29, 8'h03, 8'h00, 8'h00, 8'h32, 8'h64, 8'hA5};
        exp_q.push_back(8'hFF);
        cmp;
        wr(8'h06, 8'h80);
        wr(8'h10, 8'h1C);
        slow <= 1'b1;
        get(8'h00, 3'h0, 16'h0007);
        exp_q = '{8'h09, 8'h29, 8'h03, 8'h00, 8'h00, 8'h32, 8'h1C};
        cmp;
        slow <= 1'b0;
        get(8'h03, 3'h1, 16'h0040);
        exp_q = '{8'h04, 8'h03, 8'h09, 8'h04};
        cmp;
        t_str(3'h2, 8'h14, 8'h20, 8'h03);
        t_str(3'h3, 8'h15, 8'h40, 8'h02);
        t_str(3'h4, 8'h16, 8'h60, 8'h3C);
        t_reject;
        finish_test;
    end
endmodule // tb
